// ===== core/lane_mon_pkg.sv
// Constants, register map and types shared by the lane status monitor
package lane_mon_pkg;
  localparam int             NUM_LANES        = 20;
  localparam int             LANE_ID_W        = 5;
  localparam int             BLK_PER_CYC      = 3;
  localparam int             CLK_HZ           = 40_000_000;
  localparam int             BER_WINDOW_NS    = 125_000;
  localparam int             BER_WINDOW_CYC   = (BER_WINDOW_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam logic [7:0]     BER_BAD_LIMIT    = 8'h61;
  localparam logic [2:0]     FAULT_SEQ_LIMIT  = 3'h4;
  localparam logic [6:0]     FAULT_WINDOW_CYC = 7'h7F;
  localparam logic [4:0]     OFS_CTRL         = 5'h00;
  localparam logic [4:0]     OFS_MAXLEN       = 5'h04;
  localparam logic [4:0]     OFS_STATUS       = 5'h08;
  localparam logic [4:0]     OFS_LOCKED       = 5'h0C;
  localparam logic [4:0]     OFS_DEMUX        = 5'h10;
  localparam logic [4:0]     OFS_PARITY       = 5'h14;
  localparam int             CTRL_RX_TEST     = 0;
  localparam int             CTRL_TX_TEST     = 1;
  localparam int             CTRL_REPL        = 2;
  localparam int             CTRL_REPL_LSB    = 8;
  localparam int             ST_REMOTE        = 0;
  localparam int             ST_INT_FAULT     = 1;
  localparam int             ST_RCV_FAULT     = 2;
  localparam int             ST_HI_BER        = 3;
  localparam int             ST_ORDERSET      = 4;
  localparam int             ST_FOUR_LANE     = 5;
  localparam int             ST_ALIGNED       = 6;
  localparam int             PAR_VALID        = 8;
  localparam logic [14:0]    MAXLEN_RESET     = 15'h2580;
  localparam logic [31:0]    CTRL_RESET       = 32'h0000_0000;
  typedef enum logic [1:0] {FLT_NONE, FLT_LOCAL, FLT_REMOTE} flt_t;
endpackage : lane_mon_pkg

// ===== core/lane_status_monitor.sv
// Receive lane status, fault, error-rate and test pattern monitor with register access
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module lane_status_monitor
#(
  parameter int BER_WINDOW = lane_mon_pkg::BER_WINDOW_CYC
)
(
  input  wire logic         CORE_CLK,
  input  wire logic         RESETN,
  input  wire logic [4:0]   AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  output logic      [31:0]  AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  input  wire logic [19:0]  LANE_BLOCK_LOCK,
  input  wire logic [19:0]  LANE_MARKER_OK,
  input  wire logic [99:0]  LANE_MARKER_ID,
  input  wire logic [19:0]  LANE_MARKER_BAD,
  input  wire logic [19:0]  LANE_BIP_BAD,
  input  wire logic         METAFRAME_TICK,
  input  wire logic         SYNC_HEADER_BAD,
  input  wire logic         RX_FAULT_LOCAL_WORD,
  input  wire logic         RX_FAULT_REMOTE_WORD,
  input  wire logic         RX_SIGNAL_ORDERSET,
  input  wire logic [2:0]   RX_BLK_VALID,
  input  wire logic [2:0]   RX_BLK_IDLE,
  input  wire logic [7:0]   RX_MARKER0_PARITY_IN,
  input  wire logic         RX_MARKER0_STROBE,
  input  wire logic [7:0]   TX_MARKER0_PARITY_IN,
  input  wire logic         FOUR_LANE_SELECT_IN,
  input  wire logic         PKT_VALID,
  input  wire logic         PKT_SOP,
  input  wire logic         PKT_EOP,
  input  wire logic [6:0]   PKT_BYTES,
  input  wire logic         PKT_FCS_GOOD,
  input  wire logic         PKT_FCS_INVERTED,
  output logic              RX_LANE_MISALIGN_PULSE,
  output logic              RX_REMOTE_FAULT,
  output logic      [99:0]  RX_LANE_NUMBER,
  output logic      [19:0]  RX_LANE_WORD_LOCKED,
  output logic      [19:0]  RX_LANE_DEMUX_DONE,
  output logic      [19:0]  RX_MARKER_MALFORMED,
  output logic      [2:0]   RX_CHECKSUM_WRONG_COUNT,
  output logic      [2:0]   RX_CHECKSUM_INVERTED_COUNT,
  output logic              RX_TRUNCATED,
  output logic              RX_INTERNAL_LOCAL_FAULT,
  output logic              RX_RECEIVED_LOCAL_FAULT,
  output logic              RX_LOCAL_FAULT,
  output logic      [19:0]  RX_BIP_ERROR,
  output logic              RX_ERROR_RATE_EXCESS,
  output logic              RX_SIGNAL_ORDERSET_SEEN,
  output logic      [2:0]   RX_TEST_MISMATCH_COUNT,
  output logic              TX_TEST_PATTERN_SEND,
  output logic              FOUR_LANE_SELECT,
  output logic      [7:0]   TX_MARKER0_PARITY,
  output logic      [7:0]   RX_MARKER_PARITY_BYTE,
  output logic              RX_MARKER_PARITY_BYTE_VALID
);
  typedef struct packed {
    logic [1:0]                mode_sync;
    logic                      four_lane;
    logic                      waitreq;
    logic [31:0]               rdata;
    logic                      rx_test;
    logic                      tx_test;
    logic                      repl;
    logic [7:0]                repl_val;
    logic [14:0]               max_len;
    logic [19:0]               locked;
    logic [99:0]               lane_id;
    logic [19:0]               demux;
    logic                      all_seen;
    logic                      mis_pending;
    logic                      misalign;
    logic [19:0]               marker_bad;
    logic [19:0]               bip;
    lane_mon_pkg::flt_t        flt;
    lane_mon_pkg::flt_t        last_kind;
    logic                      remote;
    logic                      rcv_local;
    logic [2:0]                seq_cnt;
    logic [6:0]                win_cnt;
    logic [12:0]               ber_win;
    logic [7:0]                ber_cnt;
    logic                      hi_ber;
    logic                      int_fault;
    logic                      local_fault;
    logic                      orderset;
    logic [2:0]                mismatch;
    logic [7:0]                rx_par;
    logic                      rx_par_valid;
    logic [7:0]                tx_par;
  } mon_state_t;

  mon_state_t         s_r;
  mon_state_t         s_nxt;
  logic [31:0]        rd_word;
  logic [2:0]         mm;
  lane_mon_pkg::flt_t kind;
  logic               req;

  pkt_if pk ();

  assign pk.valid        = PKT_VALID;
  assign pk.sop          = PKT_SOP;
  assign pk.eop          = PKT_EOP;
  assign pk.bytes        = PKT_BYTES;
  assign pk.fcs_good     = PKT_FCS_GOOD;
  assign pk.fcs_inverted = PKT_FCS_INVERTED;
  assign pk.max_len      = s_r.max_len;

  pkt_checker u_chk
  (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .p     (pk.chk)
  );

  always_comb
  begin
    s_nxt = s_r;
    req   = AVS_READ | AVS_WRITE;
    mm    = 3'h0;
    kind  = RX_FAULT_REMOTE_WORD ? lane_mon_pkg::FLT_REMOTE : lane_mon_pkg::FLT_LOCAL;
    // Mode pin is asynchronous; only the second stage is used
    s_nxt.mode_sync = {s_r.mode_sync[0], FOUR_LANE_SELECT_IN};
    s_nxt.four_lane = s_r.mode_sync[1];
    // Lane identity and word lock per physical lane
    for (int i = 0; i < lane_mon_pkg::NUM_LANES; i++)
    begin
      if (!LANE_BLOCK_LOCK[i])
        s_nxt.locked[i] = 1'b0;
      else if (LANE_MARKER_OK[i])
      begin
        s_nxt.locked[i]        = 1'b1;
        s_nxt.lane_id[i*5 +: 5] = LANE_MARKER_ID[i*5 +: 5];
      end
    end
    for (int k = 0; k < lane_mon_pkg::NUM_LANES; k++)
    begin
      s_nxt.demux[k] = 1'b0;
      for (int i = 0; i < lane_mon_pkg::NUM_LANES; i++)
        if (s_nxt.locked[i] && s_nxt.lane_id[i*5 +: 5] == 5'(k))
          s_nxt.demux[k] = 1'b1;
    end
    // Alignment loss is judged at the metaframe that follows the bad marker
    if (&s_r.demux)
      s_nxt.all_seen = 1'b1;
    else if (s_r.locked == 20'h0_0000)
      s_nxt.all_seen = 1'b0;
    s_nxt.marker_bad = LANE_MARKER_BAD;
    s_nxt.misalign   = 1'b0;
    if (METAFRAME_TICK && s_r.mis_pending)
    begin
      s_nxt.misalign    = 1'b1;
      s_nxt.mis_pending = 1'b0;
    end
    if (s_r.all_seen && |LANE_MARKER_BAD)
      s_nxt.mis_pending = 1'b1;
    if (!s_r.all_seen)
      s_nxt.mis_pending = 1'b0;
    s_nxt.bip = LANE_BIP_BAD;
    // Fault sequence tracking: same-kind words within the window build up
    if (RX_FAULT_LOCAL_WORD || RX_FAULT_REMOTE_WORD)
    begin
      s_nxt.win_cnt   = 7'h00;
      s_nxt.last_kind = kind;
      s_nxt.seq_cnt   = (kind == s_r.last_kind && s_r.seq_cnt != 3'h0) ? s_r.seq_cnt : 3'h0;
      if (s_nxt.seq_cnt < lane_mon_pkg::FAULT_SEQ_LIMIT)
        s_nxt.seq_cnt = s_nxt.seq_cnt + 3'h1;
      if (s_nxt.seq_cnt == lane_mon_pkg::FAULT_SEQ_LIMIT)
        s_nxt.flt = kind;
    end
    else if (s_r.win_cnt == lane_mon_pkg::FAULT_WINDOW_CYC)
    begin
      s_nxt.seq_cnt   = 3'h0;
      s_nxt.flt       = lane_mon_pkg::FLT_NONE;
      s_nxt.last_kind = lane_mon_pkg::FLT_NONE;
    end
    else
      s_nxt.win_cnt = s_r.win_cnt + 7'h01;
    // Decoded here so both fault levels leave straight from a flop
    s_nxt.remote    = s_nxt.flt == lane_mon_pkg::FLT_REMOTE;
    s_nxt.rcv_local = s_nxt.flt == lane_mon_pkg::FLT_LOCAL;
    // Error rate: bad sync headers counted over a fixed window
    if (SYNC_HEADER_BAD && s_r.ber_cnt != lane_mon_pkg::BER_BAD_LIMIT)
      s_nxt.ber_cnt = s_r.ber_cnt + 8'h01;
    if (s_nxt.ber_cnt == lane_mon_pkg::BER_BAD_LIMIT)
      s_nxt.hi_ber = 1'b1;
    if (s_r.ber_win == 13'(BER_WINDOW - 1))
    begin
      // Judge the closing window before its count is cleared
      s_nxt.hi_ber  = (s_nxt.ber_cnt == lane_mon_pkg::BER_BAD_LIMIT);
      s_nxt.ber_win = 13'h0000;
      s_nxt.ber_cnt = 8'h00;
    end
    else
      s_nxt.ber_win = s_r.ber_win + 13'h0001;
    s_nxt.int_fault   = s_r.tx_test | ~(&s_r.demux) | s_r.hi_ber;
    s_nxt.local_fault = s_r.int_fault | (s_r.flt == lane_mon_pkg::FLT_LOCAL);
    // Idle pattern check, quiet outside receive test mode
    for (int j = 0; j < lane_mon_pkg::BLK_PER_CYC; j++)
      mm = mm + 3'(RX_BLK_VALID[j] & ~RX_BLK_IDLE[j]);
    s_nxt.mismatch = s_r.rx_test ? mm : 3'h0;
    if (RX_MARKER0_STROBE)
      s_nxt.rx_par = RX_MARKER0_PARITY_IN;
    s_nxt.rx_par_valid = RX_MARKER0_STROBE;
    s_nxt.tx_par = s_r.repl ? s_r.repl_val : TX_MARKER0_PARITY_IN;
    // Register read view
    rd_word = 32'h0000_0000;
    case (AVS_ADDRESS)
      lane_mon_pkg::OFS_CTRL:
      begin
        rd_word[lane_mon_pkg::CTRL_RX_TEST]          = s_r.rx_test;
        rd_word[lane_mon_pkg::CTRL_TX_TEST]          = s_r.tx_test;
        rd_word[lane_mon_pkg::CTRL_REPL]             = s_r.repl;
        rd_word[lane_mon_pkg::CTRL_REPL_LSB +: 8]    = s_r.repl_val;
      end
      lane_mon_pkg::OFS_MAXLEN: rd_word[14:0] = s_r.max_len;
      lane_mon_pkg::OFS_STATUS:
      begin
        rd_word[lane_mon_pkg::ST_REMOTE]    = s_r.flt == lane_mon_pkg::FLT_REMOTE;
        rd_word[lane_mon_pkg::ST_INT_FAULT] = s_r.int_fault;
        rd_word[lane_mon_pkg::ST_RCV_FAULT] = s_r.flt == lane_mon_pkg::FLT_LOCAL;
        rd_word[lane_mon_pkg::ST_HI_BER]    = s_r.hi_ber;
        rd_word[lane_mon_pkg::ST_ORDERSET]  = s_r.orderset;
        rd_word[lane_mon_pkg::ST_FOUR_LANE] = s_r.four_lane;
        rd_word[lane_mon_pkg::ST_ALIGNED]   = &s_r.demux;
      end
      lane_mon_pkg::OFS_LOCKED: rd_word[19:0] = s_r.locked;
      lane_mon_pkg::OFS_DEMUX:  rd_word[19:0] = s_r.demux;
      lane_mon_pkg::OFS_PARITY:
      begin
        rd_word[7:0]                     = s_r.rx_par;
        rd_word[lane_mon_pkg::PAR_VALID] = s_r.rx_par_valid;
      end
      default:                  rd_word = 32'h0000_0000;
    endcase
    // One wait cycle, then the access completes on the edge that sees waitrequest low
    s_nxt.waitreq = 1'b1;
    if (req && s_r.waitreq)
    begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = rd_word;
    end
    s_nxt.orderset = s_r.orderset;
    if (AVS_WRITE && !s_r.waitreq)
    begin
      case (AVS_ADDRESS)
        lane_mon_pkg::OFS_CTRL:
        begin
          s_nxt.rx_test  = AVS_WRITEDATA[lane_mon_pkg::CTRL_RX_TEST];
          s_nxt.tx_test  = AVS_WRITEDATA[lane_mon_pkg::CTRL_TX_TEST];
          s_nxt.repl     = AVS_WRITEDATA[lane_mon_pkg::CTRL_REPL];
          s_nxt.repl_val = AVS_WRITEDATA[lane_mon_pkg::CTRL_REPL_LSB +: 8];
        end
        lane_mon_pkg::OFS_MAXLEN: s_nxt.max_len = AVS_WRITEDATA[14:0];
        lane_mon_pkg::OFS_STATUS:
          if (AVS_WRITEDATA[lane_mon_pkg::ST_ORDERSET])
            s_nxt.orderset = 1'b0;
        default:                  s_nxt.max_len = s_r.max_len;
      endcase
    end
    // A new ordered set beats a software clear in the same cycle
    if (RX_SIGNAL_ORDERSET)
      s_nxt.orderset = 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      s_r          <= '0;
      s_r.waitreq  <= 1'b1;
      s_r.max_len  <= lane_mon_pkg::MAXLEN_RESET;
      s_r.int_fault <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign AVS_READDATA                = s_r.rdata;
  assign AVS_WAITREQUEST             = s_r.waitreq;
  assign RX_LANE_MISALIGN_PULSE      = s_r.misalign;
  assign RX_REMOTE_FAULT             = s_r.remote;
  assign RX_LANE_NUMBER              = s_r.lane_id;
  assign RX_LANE_WORD_LOCKED         = s_r.locked;
  assign RX_LANE_DEMUX_DONE          = s_r.demux;
  assign RX_MARKER_MALFORMED         = s_r.marker_bad;
  assign RX_CHECKSUM_WRONG_COUNT     = pk.bad_cnt;
  assign RX_CHECKSUM_INVERTED_COUNT  = pk.stomp_cnt;
  assign RX_TRUNCATED                = pk.trunc;
  assign RX_INTERNAL_LOCAL_FAULT     = s_r.int_fault;
  assign RX_RECEIVED_LOCAL_FAULT     = s_r.rcv_local;
  assign RX_LOCAL_FAULT              = s_r.local_fault;
  assign RX_BIP_ERROR                = s_r.bip;
  assign RX_ERROR_RATE_EXCESS        = s_r.hi_ber;
  assign RX_SIGNAL_ORDERSET_SEEN     = s_r.orderset;
  assign RX_TEST_MISMATCH_COUNT      = s_r.mismatch;
  assign TX_TEST_PATTERN_SEND        = s_r.tx_test;
  assign FOUR_LANE_SELECT            = s_r.four_lane;
  assign TX_MARKER0_PARITY           = s_r.tx_par;
  assign RX_MARKER_PARITY_BYTE       = s_r.rx_par;
  assign RX_MARKER_PARITY_BYTE_VALID = s_r.rx_par_valid;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  misalign_gate_a: assert property (s_r.misalign |-> $past(s_r.all_seen))
    else $error("misalignment before all markers seen");
  misalign_tick_a: assert property ((s_r.mis_pending && METAFRAME_TICK)
    |=> s_r.misalign)
    else $error("misalignment not reported at next metaframe");
  remote_rise_a: assert property ($rose(RX_REMOTE_FAULT) |-> $past(RX_FAULT_REMOTE_WORD))
    else $error("remote fault rose without a fault word");
  lane_id_a: assert property ((LANE_BLOCK_LOCK[0] && LANE_MARKER_OK[0])
    |=> s_r.locked[0] && s_r.lane_id[4:0] == $past(LANE_MARKER_ID[4:0]))
    else $error("lane number not captured");
  demux_idle_a: assert property ((s_r.locked == 20'h0_0000) |-> (s_r.demux == 20'h0_0000))
    else $error("lane found with no lane locked");
  int_fault_a: assert property (s_r.tx_test |=> s_r.int_fault)
    else $error("test generation without local fault");
  bip_pulse_a: assert property ((LANE_BIP_BAD != 20'h0_0000) |=> (s_r.bip == $past(LANE_BIP_BAD)))
    else $error("parity error pulse lost");
  mismatch_off_a: assert property (!s_r.rx_test |=> (s_r.mismatch == 3'h0))
    else $error("mismatch count outside test mode");
  parity_repl_a: assert property (s_r.repl |=> (TX_MARKER0_PARITY == $past(s_r.repl_val)))
    else $error("marker parity not replaced");
  orderset_a: assert property (RX_SIGNAL_ORDERSET |=> RX_SIGNAL_ORDERSET_SEEN)
    else $error("ordered set flag lost");
  bus_answer_a: assert property ((req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");

  misalign_c: cover property (s_r.misalign);
  hi_ber_c: cover property ($rose(s_r.hi_ber));
  rcv_fault_c: cover property ($rose(RX_RECEIVED_LOCAL_FAULT));
endmodule : lane_status_monitor

// ===== core/pkt_checker.sv
// Packet length truncation and checksum classification
`timescale 1ns/1ps
module pkt_checker
(
  input  wire logic clk,
  input  wire logic rst_n,
  pkt_if.chk        p
);
  typedef struct packed {
    logic [15:0] len;
    logic        cut;
    logic [2:0]  bad;
    logic [2:0]  stomp;
    logic        trunc;
  } chk_state_t;

  chk_state_t  s_r;
  chk_state_t  s_nxt;
  logic [15:0] len_base;
  logic        cut_base;
  logic [15:0] sum;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.bad   = 3'h0;
    s_nxt.stomp = 3'h0;
    s_nxt.trunc = 1'b0;
    len_base    = p.sop ? 16'h0000 : s_r.len;
    cut_base    = p.sop ? 1'b0 : s_r.cut;
    sum         = len_base + {9'h000, p.bytes};
    if (p.valid)
    begin
      s_nxt.len = sum;
      s_nxt.cut = cut_base;
      // Only the first overrun of a packet flags; the rest of it is dropped
      if (!cut_base && sum > {1'b0, p.max_len})
      begin
        s_nxt.cut   = 1'b1;
        s_nxt.trunc = 1'b1;
      end
      if (p.eop && !s_nxt.cut)
      begin
        if (p.fcs_inverted)
          s_nxt.stomp = 3'h1;
        else if (!p.fcs_good)
          s_nxt.bad = 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign p.bad_cnt   = s_r.bad;
  assign p.stomp_cnt = s_r.stomp;
  assign p.trunc     = s_r.trunc;

  stomp_not_bad_a: assert property (@(posedge clk) disable iff (!rst_n)
    (p.valid && p.eop && p.fcs_inverted) |=> (s_r.bad == 3'h0))
    else $error("inverted checksum counted as wrong");
  trunc_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.trunc |-> s_r.cut && !$past(s_r.cut && !(p.valid && p.sop)))
    else $error("truncation flagged twice for one packet");
  trunc_seen_c: cover property (@(posedge clk) disable iff (!rst_n) s_r.trunc);
endmodule : pkt_checker

// ===== core/pkt_if.sv
// Packet length truncation and end-of-frame checksum signals between the monitor and its packet checker
`timescale 1ns/1ps
interface pkt_if;
  logic        valid;
  logic        sop;
  logic        eop;
  logic [6:0]  bytes;
  logic        fcs_good;
  logic        fcs_inverted;
  logic [14:0] max_len;
  logic [2:0]  bad_cnt;
  logic [2:0]  stomp_cnt;
  logic        trunc;
  modport chk (input valid, sop, eop, bytes, fcs_good, fcs_inverted, max_len,
               output bad_cnt, stomp_cnt, trunc);
  modport src (output valid, sop, eop, bytes, fcs_good, fcs_inverted, max_len,
               input bad_cnt, stomp_cnt, trunc);
endinterface : pkt_if

// ===== test/lane_partner_model.sv
// Link partner model: lane lock, lane markers and metaframe ticks
`timescale 1ns/1ps
module lane_partner_model
(
  input  wire logic        clk,
  input  wire logic        start,
  output logic      [19:0] lock,
  output logic      [19:0] marker_ok,
  output logic      [99:0] marker_id,
  output logic             tick
);
  logic [3:0] phase_r;
  initial
  begin
    phase_r = 4'h0;
    lock = 20'h0_0000;
    marker_ok = 20'h0_0000;
    tick = 1'b0;
  end
  // Markers on all lanes together; the tick runs free, stream or not
  always @(posedge clk)
  begin
    phase_r <= phase_r + 4'h1;
    tick <= (phase_r == 4'h8);
    lock <= {20{start}};
    marker_ok <= (start && phase_r == 4'h0) ? 20'hF_FFFF : 20'h0_0000;
  end
  // Physical lane i carries PCS lane (i+7)%20; id inverted outside its marker
  always_comb
  begin
    for (int i = 0; i < 20; i++)
      marker_id[i*5+:5] = marker_ok[i] ? 5'((i + 7) % 20) : ~5'((i + 7) % 20);
  end
endmodule : lane_partner_model

// ===== test/lane_status_monitor_bench.sv
// Self-checking bench for the lane status monitor
`timescale 1ns/1ps
module lane_status_monitor_bench;
  typedef struct packed {logic good; logic inv; logic [2:0] wc; logic [2:0] ic;} pkt_row_t;
  logic        clk, rst_n, rd, wr, wait_req, tick, start, tick_q, misalign, rfault, trunc;
  logic        int_flt, rcv_flt, loc_flt, ber, os_seen, tx_tp, four_i, four_o, rpar_v;
  logic        sh_bad, flt_l, flt_r, sig_os, rstb, pv, psop, peop, pgood, pinv;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, rdv;
  logic [19:0] lock, m_ok, lane_bad, bip_bad, malformed, locked, demux, bip_err;
  logic [99:0] m_id, lane_num, expn;
  logic [2:0]  wrong_c, inv_c, tmis, blk_v, blk_i;
  logic [7:0]  txpar, txpar_in, rpar, rpar_in;
  logic [6:0]  pbytes;
  int          num_errors, num_checks, mis_n, n;
  pkt_row_t    rows [3] = '{'{1, 0, 0, 0}, '{0, 0, 1, 0}, '{0, 1, 0, 1}};

  lane_status_monitor #(.BER_WINDOW(200)) i_lane_status_monitor
  (
    .CORE_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .LANE_BLOCK_LOCK(lock), .LANE_MARKER_OK(m_ok), .LANE_MARKER_ID(m_id),
    .LANE_MARKER_BAD(lane_bad), .LANE_BIP_BAD(bip_bad), .METAFRAME_TICK(tick),
    .SYNC_HEADER_BAD(sh_bad), .RX_FAULT_LOCAL_WORD(flt_l), .RX_FAULT_REMOTE_WORD(flt_r),
    .RX_SIGNAL_ORDERSET(sig_os), .RX_BLK_VALID(blk_v), .RX_BLK_IDLE(blk_i),
    .RX_MARKER0_PARITY_IN(rpar_in), .RX_MARKER0_STROBE(rstb), .TX_MARKER0_PARITY_IN(txpar_in),
    .FOUR_LANE_SELECT_IN(four_i), .PKT_VALID(pv), .PKT_SOP(psop), .PKT_EOP(peop),
    .PKT_BYTES(pbytes), .PKT_FCS_GOOD(pgood), .PKT_FCS_INVERTED(pinv),
    .RX_LANE_MISALIGN_PULSE(misalign), .RX_REMOTE_FAULT(rfault), .RX_LANE_NUMBER(lane_num),
    .RX_LANE_WORD_LOCKED(locked), .RX_LANE_DEMUX_DONE(demux), .RX_MARKER_MALFORMED(malformed),
    .RX_CHECKSUM_WRONG_COUNT(wrong_c), .RX_CHECKSUM_INVERTED_COUNT(inv_c), .RX_TRUNCATED(trunc),
    .RX_INTERNAL_LOCAL_FAULT(int_flt), .RX_RECEIVED_LOCAL_FAULT(rcv_flt),
    .RX_LOCAL_FAULT(loc_flt), .RX_BIP_ERROR(bip_err), .RX_ERROR_RATE_EXCESS(ber),
    .RX_SIGNAL_ORDERSET_SEEN(os_seen), .RX_TEST_MISMATCH_COUNT(tmis),
    .TX_TEST_PATTERN_SEND(tx_tp), .FOUR_LANE_SELECT(four_o), .TX_MARKER0_PARITY(txpar),
    .RX_MARKER_PARITY_BYTE(rpar), .RX_MARKER_PARITY_BYTE_VALID(rpar_v)
  );
  lane_partner_model i_lane_partner_model
  (
    .clk(clk), .start(start), .lock(lock), .marker_ok(m_ok), .marker_id(m_id), .tick(tick)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tick_q <= tick;
    if (misalign === 1'b1)
      mis_n <= mis_n + 1;
  end

  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [99:0] seen, input logic [99:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low; an edge passes first
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wait_req !== 1'b0 && k < 50);
    chk("bus_wait", k < 50, 1'b1);
    if (k >= 50)
      wrap_up();
    rdv = rdata;
    {wr, rd} <= 2'b00;
  endtask : bus

  initial
  begin
    {rst_n, rd, wr, addr, wdata, start, lane_bad, bip_bad, sh_bad, flt_l, flt_r} = '0;
    {sig_os, rstb, rpar_in, four_i, pv, psop, peop, pbytes, pgood, pinv, mis_n} = '0;
    {blk_v, blk_i, txpar_in} = {3'h7, 3'h2, 8'h5A};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("wait_req", wait_req, 1'b1);
    chk("int_flt", int_flt, 1'b1);
    bus(0, 5'h04, 32'h0000_0000);
    chk("maxlen", rdv, 32'h0000_2580);
    bus(0, 5'h1C, 32'h0000_0000);
    chk("unmapped", rdv, 32'h0000_0000);
    foreach (rows[k])
    begin
      @(posedge clk) {pv, psop, peop, pbytes, pgood, pinv} <= {3'h7, 7'h40, rows[k].good, rows[k].inv};
      @(posedge clk) pv <= 1'b0;
      #1 chk("wrong_c", wrong_c, rows[k].wc);
      chk("inv_c", inv_c, rows[k].ic);
    end
    @(posedge clk) lane_bad <= 20'h0_0008;
    @(posedge clk) lane_bad <= 20'h0_0000;
    #1 chk("malformed", malformed, 20'h0_0008);
    repeat (40) @(posedge clk);
    chk("early_mis", mis_n, 0);
    @(posedge clk) start <= 1'b1;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 20; i++)
      expn[i*5+:5] = 5'((i + 7) % 20);
    #1 chk("locked", locked, 20'hF_FFFF);
    chk("demux", demux, 20'hF_FFFF);
    chk("lane_num", lane_num, expn);
    chk("int_flt", int_flt, 1'b0);
    @(posedge clk) lane_bad <= 20'h0_0001;
    @(posedge clk) lane_bad <= 20'h0_0000;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (misalign !== 1'b1 && n < 40);
    chk("mis_tick", {n < 40, tick_q}, 2'b11);
    if (n >= 40)
      wrap_up();
    @(posedge clk);
    #1 chk("mis_pulse", misalign, 1'b0);
    @(posedge clk) bip_bad <= 20'h8_0001;
    @(posedge clk) bip_bad <= 20'h0_0000;
    #1 chk("bip_err", bip_err, 20'h8_0001);
    bus(1, 5'h04, 32'h0000_0064);
    @(posedge clk) {pv, psop, peop, pbytes, pgood} <= {3'h6, 7'h40, 1'b0};
    @(posedge clk) psop <= 1'b0;
    @(posedge clk) peop <= 1'b1;
    #1 chk("trunc", trunc, 1'b1);
    @(posedge clk) {pv, peop} <= 2'b00;
    #1 chk("trunc_wc", {trunc, wrong_c}, 4'h0);
    // Four local words, then four remote words take over the fault level
    for (int f = 0; f < 8; f++)
    begin
      @(posedge clk) {flt_r, flt_l} <= {f > 3, f < 4};
      @(posedge clk) {flt_r, flt_l} <= 2'b00;
      if (f == 3)
        #1 chk("rcv_flt", {rfault, rcv_flt}, 2'b01);
    end
    #1 chk("faults", {rfault, rcv_flt}, 2'b10);
    repeat (140) @(posedge clk);
    #1 chk("faults_off", {rfault, rcv_flt, loc_flt}, 3'b000);
    @(posedge clk) sig_os <= 1'b1;
    @(posedge clk) sig_os <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("os_seen", os_seen, 1'b1);
    bus(1, 5'h08, 32'h0000_0010);
    #1 chk("os_clear", os_seen, 1'b0);
    bus(1, 5'h00, 32'h0000_3C07);
    bus(0, 5'h00, 32'h0000_0000);
    chk("ctrl", rdv, 32'h0000_3C07);
    repeat (3) @(posedge clk);
    #1 chk("test_on", {tmis, tx_tp, int_flt, txpar}, {3'h2, 2'b11, 8'h3C});
    bus(1, 5'h00, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1 chk("test_off", {tmis, tx_tp, int_flt, txpar}, {5'h00, 8'h5A});
    @(posedge clk) {rpar_in, rstb} <= {8'hA5, 1'b1};
    @(posedge clk) rstb <= 1'b0;
    #1 chk("rx_parity", {rpar, rpar_v}, {8'hA5, 1'b1});
    @(posedge clk) four_i <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("four_sync", four_o, 1'b0);
    @(posedge clk);
    #1 chk("four", four_o, 1'b1);
    @(posedge clk) sh_bad <= 1'b1;
    repeat (250) @(posedge clk);
    #1 chk("hi_ber", {ber, int_flt, loc_flt}, 3'b111);
    @(posedge clk) sh_bad <= 1'b0;
    repeat (450) @(posedge clk);
    #1 chk("ber_off", ber, 1'b0);
    @(posedge clk) start <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("unlock", {locked, int_flt}, {20'h0_0000, 1'b1});
    wrap_up();
  end
endmodule : lane_status_monitor_bench
